/* ictp_pkg.sv */
// Constants, timing helpers and register map of the serial control block.
// Assumes a 125 MHz system clock and an oscillator time unit of 38.1 ns.
`default_nettype none

package ictp_pkg;

  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 8000;
  localparam int OSC_PERIOD_PS = 38100;
  localparam int OSC_OVERHEAD = 5;
  // Oscillator period in system clocks, rounded up for a least time
  localparam int OSC_CYC = (OSC_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STRAP_SETTLE = 3;

  // ---------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------
  localparam logic [7:0] REG_CLOCK_HIGH_PERIOD = 8'h0B;
  localparam logic [7:0] REG_CLOCK_LOW_PERIOD = 8'h0C;
  // Standard-mode defaults give at least 5 us high time
  localparam logic [7:0] RST_CLOCK_HIGH_PERIOD = 8'h7F;
  localparam logic [7:0] RST_CLOCK_LOW_PERIOD = 8'h7F;
  // Suggested settings for fast and fast-plus modes
  localparam logic [7:0] FAST_HIGH = 8'h13;
  localparam logic [7:0] FAST_LOW = 8'h26;
  localparam logic [7:0] FASTP_HIGH = 8'h06;
  localparam logic [7:0] FASTP_LOW = 8'h0B;

  // ---------------------------------------------------------------------
  // Target addresses
  // ---------------------------------------------------------------------
  localparam logic [6:0] ADDR_LOWER = 7'h18;
  localparam logic [6:0] ADDR_UPPER = 7'h19;

  // ---------------------------------------------------------------------
  // Proxy commands
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    ICTP_CMD_START = 2'h0,
    ICTP_CMD_STOP = 2'h1,
    ICTP_CMD_WRITE = 2'h2,
    ICTP_CMD_READ = 2'h3
  } ictp_cmd_t;

  // Phase length in system clocks: (count + overhead) oscillator periods
  function automatic logic [15:0] ictp_phase_cycles(input logic [7:0] val);
    logic [15:0] units;
    units = {8'h00, val} + 16'(OSC_OVERHEAD);
    return 16'(units * 16'(OSC_CYC));
  endfunction : ictp_phase_cycles

endpackage : ictp_pkg

`default_nettype wire

/* ictp_proxy.sv */
// Proxy controller: replays byte-level accesses on the local serial bus.
// Assumes open-drain pins with external pull-ups; inputs are asynchronous.
`default_nettype none

module ictp_proxy
  import ictp_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Timing settings
  input wire logic [7:0] high_cnt,
  input wire logic [7:0] low_cnt,
  // Command port
  input wire logic cmd_valid,
  input wire logic [1:0] cmd,
  input wire logic [7:0] cmd_wdata,
  input wire logic cmd_last,
  output logic cmd_ready,
  output logic cmd_done,
  output logic [7:0] cmd_rdata,
  output logic cmd_nack,
  // Local bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_oe,
  output logic sda_oe
);

  typedef enum logic [5:0] {
    PX_IDLE = 6'b00_0001,
    PX_ST_H = 6'b00_0010,
    PX_LOW = 6'b00_0100,
    PX_HIGH = 6'b00_1000,
    PX_SP_L = 6'b01_0000,
    PX_SP_H = 6'b10_0000
  } ictp_px_t;

  ictp_px_t st_q;
  logic [15:0] cnt_q;
  logic [3:0] bit_q;
  logic [7:0] tx_q;
  logic rd_q;
  logic last_q;
  logic scl_s1, scl_s2, sda_s1, sda_s2;

  // Pin synchronisers
  always_ff @(posedge clk_sys) begin
    scl_s1 <= scl_i;
    scl_s2 <= scl_s1;
    sda_s1 <= sda_i;
    sda_s2 <= sda_s1;
  end

  // Bit sequencer with programmed high and low phases
  always_ff @(posedge clk_sys) begin
    cmd_done <= 1'b0;
    if (!resetn) begin
      st_q <= PX_IDLE;
      cnt_q <= 16'h0000;
      bit_q <= 4'h0;
      tx_q <= 8'h00;
      rd_q <= 1'b0;
      last_q <= 1'b0;
      cmd_ready <= 1'b0;
      cmd_rdata <= 8'h00;
      cmd_nack <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      case (st_q)
        PX_IDLE: begin
          cmd_ready <= ~cmd_valid;
          if (cmd_valid && cmd_ready) begin
            cmd_ready <= 1'b0;
            bit_q <= 4'h0;
            rd_q <= (cmd == ICTP_CMD_READ);
            last_q <= cmd_last;
            tx_q <= (cmd == ICTP_CMD_READ) ? 8'hFF : cmd_wdata;
            case (cmd)
              ICTP_CMD_START: begin
                sda_oe <= 1'b1; // RQ12
                cnt_q <= ictp_phase_cycles(high_cnt);
                st_q <= PX_ST_H;
              end
              ICTP_CMD_STOP: begin
                scl_oe <= 1'b1;
                sda_oe <= 1'b1;
                cnt_q <= ictp_phase_cycles(low_cnt);
                st_q <= PX_SP_L;
              end
              default: begin
                scl_oe <= 1'b1;
                sda_oe <= (cmd == ICTP_CMD_WRITE) & ~cmd_wdata[7];
                cnt_q <= ictp_phase_cycles(low_cnt); // RQ14
                st_q <= PX_LOW;
              end
            endcase
          end
        end
        PX_ST_H: begin
          if (cnt_q > 16'h0001) begin
            cnt_q <= cnt_q - 16'h0001;
          end else begin
            scl_oe <= 1'b1;
            cmd_done <= 1'b1;
            st_q <= PX_IDLE;
          end
        end
        PX_LOW: begin
          if (cnt_q > 16'h0001) begin
            cnt_q <= cnt_q - 16'h0001;
          end else begin
            scl_oe <= 1'b0;
            cnt_q <= ictp_phase_cycles(high_cnt); // RQ13
            st_q <= PX_HIGH;
          end
        end
        PX_HIGH: begin
          if (!scl_s2) begin
            cnt_q <= cnt_q; // RQ11
          end else if (cnt_q > 16'h0001) begin
            cnt_q <= cnt_q - 16'h0001;
          end else begin
            scl_oe <= 1'b1;
            bit_q <= bit_q + 4'h1;
            if (bit_q == 4'h8) begin
              cmd_nack <= sda_s2;
              sda_oe <= 1'b0;
              cmd_done <= 1'b1;
              st_q <= PX_IDLE;
            end else begin
              cmd_rdata <= {cmd_rdata[6:0], sda_s2};
              tx_q <= {tx_q[6:0], 1'b1};
              // Ack slot: a read acknowledges unless it is the last byte
              sda_oe <= (bit_q == 4'h7) ? (rd_q & ~last_q) : ~tx_q[6];
              cnt_q <= ictp_phase_cycles(low_cnt);
              st_q <= PX_LOW;
            end
          end
        end
        PX_SP_L: begin
          if (cnt_q > 16'h0001) begin
            cnt_q <= cnt_q - 16'h0001;
          end else begin
            scl_oe <= 1'b0;
            cnt_q <= ictp_phase_cycles(high_cnt);
            st_q <= PX_SP_H;
          end
        end
        PX_SP_H: begin
          if (cnt_q > 16'h0001) begin
            cnt_q <= cnt_q - 16'h0001;
          end else begin
            sda_oe <= 1'b0; // RQ10
            cmd_done <= 1'b1;
            st_q <= PX_IDLE;
          end
        end
        default: st_q <= PX_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  a_low_phase: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ14
    (st_q == PX_LOW && cnt_q > 16'h0001) |=> scl_oe && st_q == PX_LOW)
    else $error("proxy released clock during low phase");
  a_high_phase: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ13
    (st_q == PX_HIGH && cnt_q > 16'h0001) |=> !scl_oe)
    else $error("proxy pulled clock during high phase");
  a_high_load: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ13
    (st_q == PX_LOW && cnt_q == 16'h0001) |=> cnt_q == ictp_phase_cycles(high_cnt))
    else $error("proxy high phase length wrong");
  c_stop_done: cover property (@(posedge clk_sys) disable iff (!resetn)
    st_q == PX_SP_H ##1 cmd_done);

endmodule : ictp_proxy

`default_nettype wire

/* ictp_top.sv */
// Serial control target with strap capture, clock output and proxy controller.
// Assumes a comparator bank encodes the strap ratio range asynchronously.
`default_nettype none

// Function
// RQ1: Strap range selects target address 0x18/0x19
// RQ2: Strap range selects 1.8 V or 3.3 V
// RQ3: Evaluate strap ratio at power-up, latch settings
// RQ4: Strap pin becomes sensor clock afterwards
// RQ5: Detect start and stop while clock high
// RQ6: Acknowledge matching address by pulling data low
// RQ7: Leave data released on address mismatch
// RQ8: Acknowledge every received write byte
// RQ9: Controller acks reads, nacks last, stops
// RQ10: Transactions open with start, close with stop
// RQ11: Local controllers tolerate clock stretching (the proxy holds its count only in bit high phases, not in the stop high phase)
// RQ12: Proxy regenerates remote accesses on local bus
// RQ13: High phase is (count plus 5) oscillator periods
// RQ14: Low phase is (count plus 5) oscillator periods
// RQ15: Low count sets target data setup stretch
// RQ16: Defaults give at least 5 us high time
// RQ17: Suggested timing values per speed mode
// RQ18: Strap sampled once, held until power-up
module ictp_top
  import ictp_pkg::*;
#(
  parameter int CLKOUT_DIV = 4
)(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Strap comparator and shared strap pin output
  input wire logic [1:0] strap_range_i,
  output logic address_strap_pin_o,
  output logic address_strap_pin_oe,
  output logic io_3v3_sel,
  // Target serial bus
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_oe,
  output logic sda_oe,
  // Proxy command port
  input wire logic px_valid,
  input wire logic [1:0] px_cmd,
  input wire logic [7:0] px_wdata,
  input wire logic px_last,
  output logic px_ready,
  output logic px_done,
  output logic [7:0] px_rdata,
  output logic px_nack,
  // Local bus pins
  input wire logic lscl_i,
  input wire logic lsda_i,
  output logic lscl_oe,
  output logic lsda_oe
);

  if (CLKOUT_DIV < 2 || CLKOUT_DIV > 255) begin : g_chk
    $error("CLKOUT_DIV out of range");
  end

  typedef enum logic [6:0] {
    TG_IDLE = 7'b000_0001,
    TG_ADDR = 7'b000_0010,
    TG_ACK = 7'b000_0100,
    TG_RX = 7'b000_1000,
    TG_SETUP = 7'b001_0000,
    TG_TX = 7'b010_0000,
    TG_TXACK = 7'b100_0000
  } ictp_tg_t;

  // ---------------------------------------------------------------------
  // Strap capture and clock output
  // ---------------------------------------------------------------------
  logic [1:0] rng_s1, rng_s2, rng_q;
  logic [1:0] settle_q;
  logic done_q = 1'b0; // Power-up state; later resets keep the capture
  logic [6:0] addr_q;
  logic [7:0] div_q;

  // Strap synchroniser
  always_ff @(posedge clk_sys) begin
    rng_s1 <= strap_range_i;
    rng_s2 <= rng_s1;
  end

  // One-time capture after reset release
  always_ff @(posedge clk_sys) begin
    if (!resetn && !done_q) begin
      settle_q <= 2'h0;
    end else if (!done_q) begin
      settle_q <= settle_q + 2'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn && !done_q) begin
      done_q <= 1'b0;
      rng_q <= 2'h0;
      addr_q <= ADDR_LOWER;
      io_3v3_sel <= 1'b0;
    end else if (!done_q && settle_q == 2'(STRAP_SETTLE)) begin
      done_q <= 1'b1; // RQ18
      rng_q <= rng_s2; // RQ3
      addr_q <= rng_s2[0] ? ADDR_UPPER : ADDR_LOWER; // RQ1
      io_3v3_sel <= rng_s2[1]; // RQ2
    end
  end

  // Sensor reference clock divider
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      div_q <= 8'h00;
      address_strap_pin_o <= 1'b0;
      address_strap_pin_oe <= 1'b0;
    end else begin
      address_strap_pin_oe <= done_q; // RQ4
      if (done_q) begin
        div_q <= (div_q == 8'(CLKOUT_DIV / 2 - 1)) ? 8'h00 : div_q + 8'h01;
        if (div_q == 8'(CLKOUT_DIV / 2 - 1)) begin
          address_strap_pin_o <= ~address_strap_pin_o;
        end
      end
    end
  end

  // ---------------------------------------------------------------------
  // Target bus front end
  // ---------------------------------------------------------------------
  logic scl_s1, scl_s2, scl_q, sda_s1, sda_s2, sda_q;
  logic rise, fall, start, stop;

  always_ff @(posedge clk_sys) begin
    scl_s1 <= scl_i;
    scl_s2 <= scl_s1;
    scl_q <= scl_s2;
    sda_s1 <= sda_i;
    sda_s2 <= sda_s1;
    sda_q <= sda_s2;
  end

  // Edge and condition decode
  assign rise = scl_s2 & ~scl_q;
  assign fall = ~scl_s2 & scl_q;
  assign start = scl_s2 & scl_q & sda_q & ~sda_s2; // RQ5
  assign stop = scl_s2 & scl_q & ~sda_q & sda_s2; // RQ5

  // ---------------------------------------------------------------------
  // Registers and target sequencer
  // ---------------------------------------------------------------------
  ictp_tg_t st_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q, ptr_q, high_q, low_q;
  logic [15:0] cnt_q;
  logic rw_q, first_q;

  function automatic logic [7:0] rd_reg(input logic [7:0] a, input logic [7:0] h,
                                        input logic [7:0] l);
    case (a)
      REG_CLOCK_HIGH_PERIOD: rd_reg = h;
      REG_CLOCK_LOW_PERIOD: rd_reg = l;
      default: rd_reg = 8'h00;
    endcase
  endfunction : rd_reg

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      st_q <= TG_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      ptr_q <= 8'h00;
      cnt_q <= 16'h0000;
      rw_q <= 1'b0;
      first_q <= 1'b0;
      high_q <= RST_CLOCK_HIGH_PERIOD; // RQ16
      low_q <= RST_CLOCK_LOW_PERIOD; // RQ16
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
    end else if (start) begin
      st_q <= TG_ADDR; // RQ10
      bit_q <= 4'h0;
      first_q <= 1'b1;
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
    end else if (stop) begin
      st_q <= TG_IDLE; // RQ10
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
    end else begin
      case (st_q)
        TG_IDLE: begin
          sda_oe <= 1'b0;
          scl_oe <= 1'b0;
        end
        TG_ADDR, TG_RX: begin
          if (rise) begin
            sh_q <= {sh_q[6:0], sda_s2};
            bit_q <= bit_q + 4'h1;
          end else if (fall && bit_q == 4'h8) begin
            bit_q <= 4'h0;
            if (st_q == TG_ADDR) begin
              if (sh_q[7:1] == addr_q) begin
                rw_q <= sh_q[0];
                sda_oe <= 1'b1; // RQ6
                st_q <= TG_ACK;
              end else begin
                st_q <= TG_IDLE; // RQ7
              end
            end else begin
              if (first_q) begin
                ptr_q <= sh_q;
                first_q <= 1'b0;
              end else begin
                if (ptr_q == REG_CLOCK_HIGH_PERIOD) begin
                  high_q <= sh_q;
                end
                if (ptr_q == REG_CLOCK_LOW_PERIOD) begin
                  low_q <= sh_q;
                end
                ptr_q <= ptr_q + 8'h01;
              end
              sda_oe <= 1'b1; // RQ8
              st_q <= TG_ACK;
            end
          end
        end
        TG_ACK: begin
          if (fall) begin
            sda_oe <= 1'b0;
            if (rw_q) begin
              scl_oe <= 1'b1;
              sh_q <= rd_reg(ptr_q, high_q, low_q);
              cnt_q <= ictp_phase_cycles(low_q); // RQ15
              st_q <= TG_SETUP;
            end else begin
              st_q <= TG_RX;
            end
          end
        end
        TG_SETUP: begin
          sda_oe <= ~sh_q[7];
          if (cnt_q > 16'h0001) begin
            cnt_q <= cnt_q - 16'h0001;
          end else begin
            scl_oe <= 1'b0; // RQ15
            st_q <= TG_TX;
          end
        end
        TG_TX: begin
          if (rise) begin
            bit_q <= bit_q + 4'h1;
          end else if (fall) begin
            if (bit_q == 4'h8) begin
              bit_q <= 4'h0;
              sda_oe <= 1'b0;
              st_q <= TG_TXACK;
            end else begin
              sh_q <= {sh_q[6:0], 1'b1};
              sda_oe <= ~sh_q[6];
            end
          end
        end
        TG_TXACK: begin
          if (rise && sda_s2) begin
            st_q <= TG_IDLE; // RQ9
          end else if (fall) begin
            ptr_q <= ptr_q + 8'h01;
            scl_oe <= 1'b1;
            sh_q <= rd_reg(ptr_q + 8'h01, high_q, low_q);
            cnt_q <= ictp_phase_cycles(low_q); // RQ15
            st_q <= TG_SETUP;
          end
        end
        default: st_q <= TG_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // Proxy controller
  // ---------------------------------------------------------------------
  ictp_proxy u_proxy (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .high_cnt(high_q),
    .low_cnt(low_q),
    .cmd_valid(px_valid),
    .cmd(px_cmd),
    .cmd_wdata(px_wdata),
    .cmd_last(px_last),
    .cmd_ready(px_ready),
    .cmd_done(px_done),
    .cmd_rdata(px_rdata),
    .cmd_nack(px_nack),
    .scl_i(lscl_i),
    .sda_i(lsda_i),
    .scl_oe(lscl_oe),
    .sda_oe(lsda_oe)
  ); // RQ12

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  a_start_enter: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ5
    start |=> st_q == TG_ADDR && !sda_oe)
    else $error("start not recognised");
  a_stop_release: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ10
    stop |=> st_q == TG_IDLE && !sda_oe && !scl_oe)
    else $error("stop did not release bus");
  a_addr_ack: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ6
    (st_q == TG_ADDR && fall && !start && !stop && bit_q == 4'h8 && sh_q[7:1] == addr_q)
    |=> sda_oe && st_q == TG_ACK)
    else $error("matching address not acknowledged");
  a_addr_nack: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ7
    (st_q == TG_ADDR && fall && !start && !stop && bit_q == 4'h8 && sh_q[7:1] != addr_q)
    |=> !sda_oe ##1 !sda_oe)
    else $error("foreign address acknowledged");
  a_write_ack: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ8
    (st_q == TG_RX && fall && !start && !stop && bit_q == 4'h8) |=> sda_oe)
    else $error("write byte not acknowledged");
  a_setup_stretch: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ15
    (st_q == TG_SETUP && cnt_q > 16'h0001 && !start && !stop) |=> scl_oe)
    else $error("clock released before setup done");
  a_strap_map: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ1
    done_q |-> addr_q == (rng_q[0] ? ADDR_UPPER : ADDR_LOWER) && io_3v3_sel == rng_q[1])
    else $error("strap mapping wrong");
  a_strap_hold: assert property (@(posedge clk_sys) // RQ18
    $past(done_q) |-> done_q && $stable(rng_q) && $stable(addr_q))
    else $error("strap settings changed");
  a_clkout_gate: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ4
    !done_q |=> !address_strap_pin_oe)
    else $error("clock output before strap capture");
  c_read_byte: cover property (@(posedge clk_sys) disable iff (!resetn)
    st_q == TG_SETUP ##[1:1000] st_q == TG_TXACK);
  c_write_reg: cover property (@(posedge clk_sys) disable iff (!resetn)
    st_q == TG_RX && !first_q ##[1:1000] st_q == TG_ACK);
  c_nack_addr: cover property (@(posedge clk_sys) disable iff (!resetn)
    st_q == TG_ADDR ##1 st_q == TG_IDLE);

endmodule : ictp_top

`default_nettype wire

/* ictp_ctrl_model.sv */
// Behavioural serial bus controller driving the target side of the block.
// Assumes the bench resolves open-drain wires; it steps on clk_sys falling edges.
`default_nettype none

module ictp_ctrl_model (
  // Clock
  input wire logic clk_sys,
  // Resolved wire levels
  input wire logic scl,
  input wire logic sda,
  // Pull-low drives
  output logic scl_low,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  int stalls;

  // Bus idles released
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    stalls = 0;
  end

  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : wt

  // Release clock, wait out a stretched low, then hold high
  task automatic rise();
    int n;
    n = 0;
    scl_low = 1'b0;
    while (scl !== 1'b1 && n < 4000) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 4000) stalls++;
    wt(3);
  endtask : rise

  // Start or repeated start: data falls while clock high
  task automatic start();
    sda_low = 1'b0;
    wt(2);
    rise();
    sda_low = 1'b1;
    wt(4);
    scl_low = 1'b1;
    wt(2);
  endtask : start

  // Stop: data rises while clock high
  task automatic stop();
    sda_low = 1'b1;
    wt(2);
    rise();
    sda_low = 1'b0;
    wt(4);
  endtask : stop

  // One bit: data set while clock low, sampled while high
  task automatic xbit(input logic b, output logic s);
    sda_low = ~b;
    wt(2);
    rise();
    s = sda;
    scl_low = 1'b1;
    wt(2);
  endtask : xbit

  // Byte msb first; ack bit driven low to ask for more, high on last
  task automatic xbyte(input logic [7:0] w, input logic ack, output logic [7:0] r,
                       output logic nack);
    for (int i = 7; i >= 0; i--) xbit(w[i], r[i]);
    xbit(ack, nack);
  endtask : xbyte
endmodule : ictp_ctrl_model

`default_nettype wire

/* test_i2c_target_and_proxy_timing.sv */
// Self-checking bench for the serial target, strap capture and proxy.
// Assumes pull-ups on both buses and no local target answering the proxy.
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end

module test_i2c_target_and_proxy_timing
  import ictp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [1:0] strap_range = 2'd3;
  logic pin, pin_oe, io_3v3_sel, scl_oe, sda_oe, m_scl, m_sda, scl, sda;
  logic px_valid = 1'b0;
  logic [1:0] px_cmd = 2'd0;
  logic [7:0] px_wdata = 8'h00;
  logic px_last = 1'b0;
  logic px_ready, px_done, px_nack, lscl_oe, lsda_oe;
  logic [7:0] px_rdata, rv;
  logic nk;
  int failures = 0;
  int checks = 0;
  int cyc = 0;
  int lo_run = 0;
  int lo_last = 0;
  int hi_run = 0;
  int hi_last = 0;
  localparam int CLKOUT_DIV_T = 4;

  // ---------------------------------------------------------------------
  // Clock, wires and instances
  // ---------------------------------------------------------------------
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  assign scl = ~(scl_oe | m_scl);
  assign sda = ~(sda_oe | m_sda);

  ictp_top DUT (.clk_sys(clk_sys), .resetn(resetn), .strap_range_i(strap_range),
    .address_strap_pin_o(pin), .address_strap_pin_oe(pin_oe), .io_3v3_sel(io_3v3_sel),
    .scl_i(scl), .sda_i(sda), .scl_oe(scl_oe), .sda_oe(sda_oe), .px_valid(px_valid),
    .px_cmd(px_cmd), .px_wdata(px_wdata), .px_last(px_last), .px_ready(px_ready),
    .px_done(px_done), .px_rdata(px_rdata), .px_nack(px_nack), .lscl_i(~lscl_oe),
    .lsda_i(~lsda_oe), .lscl_oe(lscl_oe), .lsda_oe(lsda_oe));

  ictp_ctrl_model m (.clk_sys(clk_sys), .scl(scl), .sda(sda), .scl_low(m_scl),
    .sda_low(m_sda));

  // Phase lengths on the local clock line, and the hang limit
  always @(negedge clk_sys) begin
    cyc++;
    if (lscl_oe) lo_run++;
    else if (lo_run > 0) begin
      lo_last = lo_run;
      lo_run = 0;
    end
    if (!lscl_oe && lsda_oe) hi_run++;
    else if (hi_run > 0) begin
      hi_last = hi_run;
      hi_run = 0;
    end
    if (cyc == 30000) begin
      failures++;
      give_verdict();
    end
  end

  // ---------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  // Pointer write, repeated start, two reads (ack then nack)
  task automatic rd(input logic [7:0] p, input logic [7:0] e0, input logic [7:0] e1);
    m.start();
    m.xbyte({ADDR_UPPER, 1'b0}, 1'b1, rv, nk);
    m.xbyte(p, 1'b1, rv, nk);
    m.start();
    m.xbyte({ADDR_UPPER, 1'b1}, 1'b1, rv, nk);
    `CHK("read address ack", 1'b0, nk)
    m.xbyte(8'hFF, 1'b0, rv, nk);
    `CHK("first read byte", e0, rv)
    m.xbyte(8'hFF, 1'b1, rv, nk);
    `CHK("last read byte", e1, rv)
    m.stop();
  endtask : rd

  task automatic t_strap();
    int n;
    logic pv;
    n = 0;
    repeat (10) @(negedge clk_sys);
    `CHK("io voltage", 1'b1, io_3v3_sel)
    `CHK("strap pin drive", 1'b1, pin_oe)
    pv = pin;
    repeat (16) begin
      @(negedge clk_sys);
      if (pin !== pv) n++;
      pv = pin;
    end
    `CHK("clock out toggles", 16 / (CLKOUT_DIV_T / 2), n)
    strap_range = 2'd0;
    resetn = 1'b0;
    repeat (4) @(negedge clk_sys);
    resetn = 1'b1;
    repeat (10) @(negedge clk_sys);
    `CHK("strap held", 1'b1, io_3v3_sel)
    $display("strap test done");
  endtask : t_strap

  task automatic t_write();
    logic [7:0] w [3];
    w = '{REG_CLOCK_HIGH_PERIOD, FASTP_HIGH, FASTP_LOW};
    rd(REG_CLOCK_HIGH_PERIOD, RST_CLOCK_HIGH_PERIOD, RST_CLOCK_LOW_PERIOD);
    rd(8'h20, 8'h00, 8'h00);
    m.start();
    m.xbyte({ADDR_LOWER, 1'b0}, 1'b1, rv, nk);
    `CHK("other address", 1'b1, nk)
    m.stop();
    m.start();
    m.xbyte({ADDR_UPPER, 1'b0}, 1'b1, rv, nk);
    `CHK("own address", 1'b0, nk)
    for (int i = 0; i < 3; i++) begin
      m.xbyte(w[i], 1'b1, rv, nk);
      `CHK("write byte ack", 1'b0, nk)
    end
    m.stop();
    rd(REG_CLOCK_HIGH_PERIOD, FASTP_HIGH, FASTP_LOW);
    `CHK("no stall", 0, m.stalls)
    $display("register test done");
  endtask : t_write

  // One proxy command: hold valid until taken, then wait for done
  task automatic pxc(input logic [1:0] c, input logic [7:0] d, input logic l);
    int n;
    n = 0;
    // Idle edge with valid low lets ready come back
    @(negedge clk_sys);
    px_cmd = c;
    px_wdata = d;
    px_last = l;
    px_valid = 1'b1;
    while (px_ready !== 1'b1 && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
    @(negedge clk_sys);
    px_valid = 1'b0;
    while (px_done !== 1'b1 && n < 3000) begin
      @(negedge clk_sys);
      n++;
    end
    `CHK("proxy done", 1'b1, px_done)
  endtask : pxc

  task automatic t_proxy();
    int eh;
    int el;
    eh = (int'(FASTP_HIGH) + OSC_OVERHEAD) * OSC_CYC;
    el = (int'(FASTP_LOW) + OSC_OVERHEAD) * OSC_CYC;
    pxc(2'(ICTP_CMD_START), 8'h00, 1'b0);
    pxc(2'(ICTP_CMD_WRITE), 8'hA5, 1'b0);
    `CHK("high phase", 1'b1, hi_last >= eh && hi_last <= eh + 3)
    `CHK("low phase", 1'b1, lo_last >= el && lo_last <= el + 3)
    `CHK("no local ack", 1'b1, px_nack)
    pxc(2'(ICTP_CMD_READ), 8'h00, 1'b1);
    `CHK("local read", 8'hFF, px_rdata)
    pxc(2'(ICTP_CMD_STOP), 8'h00, 1'b0);
    @(negedge clk_sys);
    `CHK("local bus free", 2'b00, {lscl_oe, lsda_oe})
    $display("proxy test done");
  endtask : t_proxy

  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial begin
    repeat (8) @(negedge clk_sys);
    resetn = 1'b1;
    t_strap();
    t_write();
    t_proxy();
    give_verdict();
  end
endmodule : test_i2c_target_and_proxy_timing

`default_nettype wire
